// ==== dv/video_window_overlay_and_capture_tb_top.sv ====
// register-driven bench for overlay keying, brightness, zoom and capture
module video_window_overlay_and_capture_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdata;
  vwo_pkg::vid_in_t vidIn = '0;
  logic vidReady;
  vwo_pkg::disp_in_t dispIn = '0;
  vwo_pkg::disp_out_t dispOut;
  logic vLineAdvance;
  logic [2:0] vWeight;
  vwo_pkg::cap_in_t capIn;
  vwo_pkg::cap_out_t capOut;
  logic [21:0] displayBase;
  logic [21:0] capBase = {4'h3, 8'h22, 7'h08, 3'h0};
  logic [7:0] v;
  int miscompares = 0;
  int samples_checked = 0;
  int nW = 0;
  int nAdv = 0;
  int step = 2;
  int tot = 0;
  int cf = 0;
  logic [15:0] pd = 16'h0000;
  logic [15:0] expData;
  video_window_overlay_and_capture video_window_overlay_and_capture_inst (
    .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .vidIn(vidIn), .vidReady(vidReady), .dispIn(dispIn),
    .dispOut(dispOut), .vLineAdvance(vLineAdvance), .vWeight(vWeight), .capIn(capIn), .capOut(capOut),
    .displayBase(displayBase));
  vwo_video_source vwo_video_source_inst (.clk(clk), .capIn(capIn));
  initial forever #12.5 clk = ~clk;
  task automatic note(input bit ok, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (!ok) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic chkA(input logic [21:0] g, input logic [21:0] e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic chkF(input logic g, input logic e);
    note(g === e, 32'(g), 32'(e));
  endtask
  task automatic chkN(input int g, input int e);
    note(g == e, g, e);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
    end
    @(posedge clk) regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) begin
      regAddr <= a;
      regRead <= 1'b1;
    end
    @(posedge clk) regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  // one refresh pixel starting a line, result seen the cycle after
  task automatic disp(input logic win, input logic [15:0] g, input logic e);
    @(posedge clk) dispIn <= '{1'b1, win, 1'b1, g};
    @(posedge clk) dispIn.valid <= 1'b0;
    #1 chkF(dispOut.valid, 1'b1);
    chkF(dispOut.showVideo, e);
    chkA(22'(dispOut.gfx), 22'(g));
  endtask
  // two window pixels so both zoom slots hold pixels keyed with the current registers
  task automatic flush();
    repeat (2) begin
      @(posedge clk) dispIn <= '{1'b1, 1'b1, 1'b1, 16'h0000};
      @(posedge clk) dispIn.valid <= 1'b0;
      #1 chkF(dispOut.valid, 1'b1);
    end
  endtask
  task automatic key(input logic [7:0] kc, kv, km, input logic [15:0] g, input logic win, e);
    wr(vwo_pkg::A_KEYCTL, kc);
    wr(vwo_pkg::A_KEYV, kv);
    wr(vwo_pkg::A_KEYM, km);
    flush();
    disp(win, g, e);
  endtask
  // fields of alternating parity, odd first; total of capture writes
  task automatic fields(input int n, input int e);
    tot = 0;
    for (int f = 0; f < n; f++) begin
      nW = 0;
      vwo_video_source_inst.send_field(f[0] == 1'b0, 4);
      tot += nW;
    end
    chkN(tot, e);
  endtask
  task automatic sel(input logic [7:0] inCtl, input logic [7:0] b2Hi, input int e);
    wr(vwo_pkg::A_INCTL, inCtl);
    wr(vwo_pkg::A_B2HI, b2Hi);
    fields(4, e);
  endtask
  task automatic zoom(input logic [7:0] ctl, input logic [7:0] code, input int e);
    wr(vwo_pkg::A_WINCTL, ctl);
    wr(vwo_pkg::A_VZOOM, code);
    nAdv = 0;
    repeat (8) disp(1'b1, 16'h0000, 1'b1);
    repeat (3) @(posedge clk);
    chkN(nAdv, e);
  endtask
  // capture addresses walk up from buffer two; line fetch pulses counted
  always @(posedge clk) begin
    if (capOut.write && step != 0) chkA(capOut.addr, capBase + 22'(nW * step));
    expData = (cf == 3) ? {8'h00, pd[15:11], pd[7:5]} : ((cf == 7) ? {8'h00, pd[15:8]} : pd);
    if (capOut.write) chkA(22'(capOut.data), 22'(expData));
    pd <= capIn.data;
    if (capOut.write) nW++;
    if (vLineAdvance) nAdv++;
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    vidIn <= '{1'b1, 16'h8040, '{8'h20, 8'h30, 8'h40}};
    // reset value, read-back and clear of registers 0 to 18 (status excluded), then an unmapped index
    for (int i = 0; i < vwo_pkg::NREG; i++) begin
      rd(8'(i), v);
      chk8(v, vwo_pkg::REG_RESET);
      wr(8'(i), 8'(i) ^ 8'h5A);
      rd(8'(i), v);
      chk8(v, 8'(i) ^ 8'h5A);
      wr(8'(i), 8'h00);
    end
    rd(8'h40, v);
    chk8(v, 8'h00);
    chkF(vidReady, 1'b0);
    wr(vwo_pkg::A_B1LO, 8'hFF);
    wr(vwo_pkg::A_B1MID, 8'hAB);
    wr(vwo_pkg::A_B1HI, 8'hF5);
    repeat (2) @(posedge clk);
    #1 chkA(displayBase, {4'h5, 8'hAB, 7'h7F, 3'h0});
    // capture: enabling after the reference fall waits for the next field
    wr(vwo_pkg::A_B2LO, 8'h11);
    wr(vwo_pkg::A_B2MID, 8'h22);
    wr(vwo_pkg::A_INCTL, 8'h01);
    fork
      fields(1, 0);
      begin
        repeat (4) @(posedge clk);
        wr(vwo_pkg::A_CAPCTL, 8'h08);
      end
    join
    sel(8'h01, 8'h03, 16);
    sel(8'h81, 8'h03, 8);
    sel(8'h81, 8'h43, 8);
    sel(8'h85, 8'h03, 4);
    sel(8'h85, 8'h43, 4);
    sel(8'h05, 8'h03, 16);
    sel(8'h00, 8'h03, 0);
    wr(vwo_pkg::A_INCTL, 8'h01);
    for (int f = 0; f < 8; f++) begin
      wr(vwo_pkg::A_CAPCTL, 8'h08 | 8'(f));
      step = (f == 3 || f == 7) ? 1 : 2;
      cf = f;
      fields(1, (f > 3 && f < 7) ? 0 : 4);
    end
    wr(vwo_pkg::A_CAPCTL, 8'h00);
    cf = 0;
    // overlay with line replication, as occlusion demands
    wr(vwo_pkg::A_WINCTL, 8'h90);
    key(8'h00, 8'h3C, 8'h0F, 16'h0035, 1'b1, 1'b1);
    key(8'h00, 8'h3C, 8'h0F, 16'h0075, 1'b1, 1'b0);
    key(8'h00, 8'h3C, 8'h0F, 16'h0035, 1'b0, 1'b0);
    key(8'h08, 8'h34, 8'h12, 16'h1234, 1'b1, 1'b1);
    key(8'h08, 8'h34, 8'h12, 16'h1235, 1'b1, 1'b0);
    key(8'h18, 8'h00, 8'h80, 16'h8000, 1'b1, 1'b1);
    key(8'h18, 8'h00, 8'h80, 16'h7FFF, 1'b1, 1'b0);
    wr(vwo_pkg::A_SMIN, 8'h30);
    wr(vwo_pkg::A_SMAX, 8'h90);
    wr(vwo_pkg::A_TMIN, 8'h00);
    wr(vwo_pkg::A_TMAX, 8'h40);
    key(8'h20, 8'h80, 8'h80, 16'h0000, 1'b1, 1'b0);
    key(8'h20, 8'h81, 8'hFF, 16'h0000, 1'b1, 1'b1);
    wr(vwo_pkg::A_WINCTL, 8'h94);
    key(8'h20, 8'h20, 8'h20, 16'h0000, 1'b1, 1'b0);
    key(8'h20, 8'h80, 8'h80, 16'h0000, 1'b1, 1'b1);
    wr(vwo_pkg::A_WINCTL, 8'h10);
    disp(1'b1, 16'h0075, 1'b1);
    wr(vwo_pkg::A_BRIGHT, 8'hF4);
    flush();
    disp(1'b1, 16'h0000, 1'b1);
    chk8(dispOut.video.c0, 8'h94);
    wr(vwo_pkg::A_BRIGHT, 8'h00);
    zoom(8'h10, 8'h80, 4);
    zoom(8'h00, 8'h00, 8);
    zoom(8'h00, 8'h80, 4);
    zoom(8'h00, 8'h40, 2);
    wrap_up();
  end
endmodule

// ==== dv/vwo_monitor.sv ====
// port checker for the video window overlay and capture block
module vwo_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire vwo_pkg::disp_in_t dispIn,
  input wire vwo_pkg::disp_out_t dispOut,
  input wire logic [2:0] vWeight,
  input wire vwo_pkg::cap_in_t capIn,
  input wire vwo_pkg::cap_out_t capOut,
  input wire logic [21:0] displayBase
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shadow [256];
  logic keyMiss;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // copy of every register as software last wrote it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 256; i++) shadow[i] <= 8'h00;
    end else if (regWrite) begin
      shadow[regAddr] <= regWdata;
    end
  end
  wire [7:0] keyCtl = shadow[vwo_pkg::A_KEYCTL];
  wire [7:0] keyV = shadow[vwo_pkg::A_KEYV];
  wire [7:0] keyM = shadow[vwo_pkg::A_KEYM];
  wire [2:0] capFmt = shadow[vwo_pkg::A_CAPCTL][2:0];
  wire capOn = shadow[vwo_pkg::A_CAPCTL][vwo_pkg::CC_EN] && shadow[vwo_pkg::A_INCTL][1:0] == vwo_pkg::SRC_VPORT;
  wire [21:0] b1 = {shadow[vwo_pkg::A_B1HI][3:0], shadow[vwo_pkg::A_B1MID], shadow[vwo_pkg::A_B1LO][7:1], 3'h0};
  // graphics pixel fails the colour key in compare mode 00, 01 or 11; held low in reserved mode 10
  always_comb begin
    case (keyCtl[4:3])
      vwo_pkg::KM_MASK8: keyMiss = |((dispIn.gfx[7:0] ^ keyV) & ~keyM);
      vwo_pkg::KM_FULL16: keyMiss = dispIn.gfx != {keyM, keyV};
      vwo_pkg::KM_TOPBIT: keyMiss = dispIn.gfx[15] != keyM[7];
      default: keyMiss = 1'b0;
    endcase
  end
  a_base_follows: assert property ($stable(b1) [*3] |-> displayBase == b1)
    else $error("display base differs from buffer one start");
  a_show_outside: assert property (dispIn.valid && !dispIn.inWindow |=> dispOut.valid && !dispOut.showVideo)
    else $error("video shown outside window");
  a_key_miss: assert property (dispIn.valid && dispIn.inWindow && shadow[vwo_pkg::A_WINCTL][vwo_pkg::WC_OCCL]
    && !keyCtl[vwo_pkg::KC_SRC] && keyMiss |=> !dispOut.showVideo) else $error("video shown on key miss");
  a_weight_levels: assert property (vWeight <= 3'h4)
    else $error("vertical weight beyond five levels");
  a_cap_quiet: assert property (!capOn [*3] |-> !capOut.write)
    else $error("capture write while capture off");
  a_cap_reserved: assert property ((capFmt inside {3'h4, 3'h5, 3'h6}) [*3] |-> !capOut.write)
    else $error("capture write in reserved format");
  a_write_vact: assert property (capOut.write |-> $past(capIn.vact))
    else $error("capture write without active video");
  a_byte_mode: assert property (capOut.write |-> capOut.byteMode == (capFmt inside {3'h3, 3'h7}))
    else $error("byte mode does not match format");
  a_addr_step: assert property (capOut.write ##1 capOut.write |->
    capOut.addr == $past(capOut.addr) + (capOut.byteMode ? 22'h1 : 22'h2)) else $error("capture address step wrong");
endmodule
bind video_window_overlay_and_capture vwo_monitor vwo_monitor_inst (
  .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .dispIn(dispIn), .dispOut(dispOut), .vWeight(vWeight), .capIn(capIn), .capOut(capOut),
  .displayBase(displayBase)
);

// ==== dv/vwo_video_source.sv ====
// behavioural video port source driving reference, active flag and pixel words
module vwo_video_source (
  input wire logic clk,
  output vwo_pkg::cap_in_t capIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic vref = 1'b0;
  logic href = 1'b0;
  logic vact = 1'b0;
  logic [15:0] word = 16'h1234;
  assign capIn = '{vref, href, vact, word};
  // words count while active, flip when idle so nothing stale looks valid
  always @(posedge clk) word <= vact ? word + 16'h0101 : ~word;
  // one field: reference pulse, parity held on href at its fall, one active run
  task automatic send_field(input logic odd, input int n);
    @(posedge clk) vref <= 1'b1;
    href <= odd;
    repeat (2) @(posedge clk);
    vref <= 1'b0;
    repeat (6) @(posedge clk);
    vact <= 1'b1;
    repeat (n) @(posedge clk);
    vact <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
endmodule

// ==== pkg/vwo_pkg.sv ====
// shared constants and types for the video window overlay and capture block
package vwo_pkg;
  // register indices on the plain register port
  localparam logic [7:0] A_HZOOM = 8'h00;
  localparam logic [7:0] A_VZOOM = 8'h01;
  localparam logic [7:0] A_KEYV = 8'h02;
  localparam logic [7:0] A_KEYM = 8'h03;
  localparam logic [7:0] A_SMIN = 8'h04;
  localparam logic [7:0] A_SMAX = 8'h05;
  localparam logic [7:0] A_TMIN = 8'h06;
  localparam logic [7:0] A_TMAX = 8'h07;
  localparam logic [7:0] A_BRIGHT = 8'h08;
  localparam logic [7:0] A_B1LO = 8'h09;
  localparam logic [7:0] A_B1MID = 8'h0A;
  localparam logic [7:0] A_B1HI = 8'h0B;
  localparam logic [7:0] A_B2LO = 8'h0C;
  localparam logic [7:0] A_B2MID = 8'h0D;
  localparam logic [7:0] A_B2HI = 8'h0E;
  localparam logic [7:0] A_WINCTL = 8'h0F;
  localparam logic [7:0] A_KEYCTL = 8'h10;
  localparam logic [7:0] A_CAPCTL = 8'h11;
  localparam logic [7:0] A_INCTL = 8'h12;
  localparam logic [7:0] A_STATUS = 8'h13;
  localparam int NREG = 19;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int WC_OCCL = 7;
  localparam int WC_LREP = 4;
  localparam int WC_FMT = 1;
  localparam int KC_SRC = 5;
  localparam int KC_MODE = 3;
  localparam int CC_EN = 3;
  localparam int IC_FS = 7;
  localparam int IC_ALT = 2;
  localparam int B2_POL = 6;
  localparam int ST_ACTIVE = 0;
  localparam int ST_ODD = 1;
  localparam int ST_UNDER = 2;
  // display formats
  localparam logic [2:0] DF_YUV = 3'h0;
  localparam logic [2:0] DF_PACK = 3'h1;
  localparam logic [2:0] DF_LUT = 3'h2;
  localparam logic [2:0] DF_555 = 3'h4;
  localparam logic [2:0] DF_565 = 3'h5;
  // capture formats
  localparam logic [2:0] CF_YUV = 3'h0;
  localparam logic [2:0] CF_RGB = 3'h1;
  localparam logic [2:0] CF_PACK = 3'h2;
  localparam logic [2:0] CF_COMP = 3'h3;
  localparam logic [2:0] CF_LUMA = 3'h7;
  // key compare modes and input source
  localparam logic [1:0] KM_MASK8 = 2'h0;
  localparam logic [1:0] KM_FULL16 = 2'h1;
  localparam logic [1:0] KM_TOPBIT = 2'h3;
  localparam logic [1:0] SRC_VPORT = 2'h1;
  // zoom arithmetic
  localparam logic [8:0] ZOOM_UNITY = 9'h100;
  localparam logic [8:0] W_ROUND = 9'h020;
  localparam logic [2:0] W_FULL = 3'h4;
  localparam logic [4:0] PACK_LAST = 5'h03;

  typedef struct packed {logic [7:0] c0; logic [7:0] c1; logic [7:0] c2;} pix_t;
  typedef struct packed {logic valid; logic [15:0] data; pix_t lut;} vid_in_t;
  typedef struct packed {logic valid; logic inWindow; logic lineStart; logic [15:0] gfx;} disp_in_t;
  typedef struct packed {logic valid; logic showVideo; pix_t video; logic [15:0] gfx;} disp_out_t;
  typedef struct packed {logic vref; logic href; logic vact; logic [15:0] data;} cap_in_t;
  typedef struct packed {logic write; logic byteMode; logic [21:0] addr; logic [15:0] data;} cap_out_t;
endpackage

// ==== rtl/video_window_overlay_and_capture.sv ====
// video window zoom, overlay keying, brightness and field capture
//
// How it works
// - horizontal and vertical zoom codes give factor 256 over code.
// - zoom code zero means one-to-one, zoom off.
// - horizontal zoom always interpolates with five weight levels.
// - vertical line replication when select bit set, else interpolation weight.
// - occlusion picks video or graphics per pixel, inside window only.
// - key source bit: zero keys graphics, one keys video ranges.
// - graphics key match shows video, otherwise graphics.
// - mode 00 is 8-bit compare, mask ones ignore key bits.
// - mode 01 is 16-bit compare, key low byte, mask high byte.
// - mode 11 compares mask bit 7 with pixel bit 15; 10 reserved.
// - video key tests three components against min/max pairs.
// - video key test before zoom, after lookup or packed expansion.
// - all components inside inclusive ranges shows graphics instead.
// - 5-bit brightness added to luma of YUV pixels in window.
// - packed 4:1:1 expands to YUV 4:2:2 and shows only in window.
// - capture needs enable and video port source, starts next vertical pulse.
// - capture every field, odd only or even only.
// - alternate bit, with field select set, takes every other selected field.
// - capture format codes; reserved codes store nothing.
// - buffer starts from bits 21:3, low three bits zero.
// - window display format codes; reserved codes show graphics.
//
// Decided for this implementation: the register offsets and strobed register access.
module video_window_overlay_and_capture (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire vwo_pkg::vid_in_t vidIn,
  output logic vidReady,
  input wire vwo_pkg::disp_in_t dispIn,
  output vwo_pkg::disp_out_t dispOut,
  output logic vLineAdvance,
  output logic [2:0] vWeight,
  input wire vwo_pkg::cap_in_t capIn,
  output vwo_pkg::cap_out_t capOut,
  output logic [21:0] displayBase
);
  typedef struct packed {
    logic [vwo_pkg::NREG-1:0][7:0] regs;
    logic [7:0] rdata;
    logic under;
    // source conversion
    logic [7:0] heldU;
    logic [7:0] heldV;
    logic [1:0] chromaCnt;
    // horizontal zoom engine
    vwo_pkg::pix_t pixA;
    vwo_pkg::pix_t pixB;
    logic hitA;
    logic hitB;
    logic validA;
    logic validB;
    logic ready;
    logic [7:0] hPhase;
    vwo_pkg::disp_out_t dout;
    // vertical zoom
    logic [7:0] vPhase;
    logic lineAdv;
    logic [2:0] vW;
    // capture
    logic vrefPrev;
    logic enPrev;
    logic armed;
    logic take;
    logic odd;
    logic altSkip;
    vwo_pkg::cap_out_t cout;
    logic [21:0] dispBase;
  } state_t;

  state_t cur;
  state_t next_cur;

  // combinational helpers
  logic [2:0] dfmt;
  logic [2:0] cfmt;
  logic [1:0] kmode;
  logic occl;
  logic keySrc;
  logic capOn;
  vwo_pkg::pix_t srcPix;
  logic srcHit;
  logic accept;
  logic [8:0] hStep;
  logic [8:0] vStep;
  logic [8:0] hSum;
  logic [8:0] vSum;
  logic [2:0] hW;
  logic gMatch;
  vwo_pkg::pix_t mixPix;
  logic mixHit;
  logic [8:0] bright;
  logic [21:0] capBase;
  logic fieldOdd;
  logic fieldMatch;

  // weighted average of two component bytes, weight 0..4 toward b
  function automatic logic [7:0] blend(input logic [7:0] a, input logic [7:0] b, input logic [2:0] w);
    logic [10:0] acc;
    acc = 11'({a} * (vwo_pkg::W_FULL - w)) + 11'({b} * w);
    return acc[9:2];
  endfunction

  // inclusive range test
  function automatic logic inRange(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  always_comb begin
    next_cur = cur;
    dfmt = cur.regs[vwo_pkg::A_WINCTL][vwo_pkg::WC_FMT +: 3];
    cfmt = cur.regs[vwo_pkg::A_CAPCTL][2:0];
    kmode = cur.regs[vwo_pkg::A_KEYCTL][vwo_pkg::KC_MODE +: 2];
    occl = cur.regs[vwo_pkg::A_WINCTL][vwo_pkg::WC_OCCL];
    keySrc = cur.regs[vwo_pkg::A_KEYCTL][vwo_pkg::KC_SRC];
    capOn = cur.regs[vwo_pkg::A_CAPCTL][vwo_pkg::CC_EN]
      && (cur.regs[vwo_pkg::A_INCTL][1:0] == vwo_pkg::SRC_VPORT);

    // register port: read data one cycle after the strobe
    next_cur.rdata = 8'h00;
    if (regRead) begin
      if (regAddr < 8'(vwo_pkg::NREG)) begin
        next_cur.rdata = cur.regs[regAddr[4:0]];
      end else if (regAddr == vwo_pkg::A_STATUS) begin
        next_cur.rdata = {5'h00, cur.under, cur.odd, cur.take};
      end
    end
    if (regWrite && regAddr < 8'(vwo_pkg::NREG)) begin
      next_cur.regs[regAddr[4:0]] = regWdata;
    end

    // source conversion to three components
    srcPix = '0;
    case (dfmt)
      vwo_pkg::DF_YUV: begin
        srcPix.c0 = vidIn.data[15:8];
        srcPix.c1 = cur.chromaCnt[0] ? cur.heldU : vidIn.data[7:0];
        srcPix.c2 = cur.chromaCnt[0] ? vidIn.data[7:0] : cur.heldV;
      end
      vwo_pkg::DF_PACK: begin // expand group of four to 4:2:2
        srcPix.c0 = vidIn.data[15:8];
        srcPix.c1 = (cur.chromaCnt == 2'h0) ? vidIn.data[7:0] : cur.heldU;
        srcPix.c2 = (cur.chromaCnt == 2'h1) ? vidIn.data[7:0] : cur.heldV;
      end
      vwo_pkg::DF_LUT: srcPix = vidIn.lut; // key after palette lookup
      vwo_pkg::DF_555: srcPix = {vidIn.data[14:10], 3'h0, vidIn.data[9:5], 3'h0, vidIn.data[4:0], 3'h0};
      vwo_pkg::DF_565: srcPix = {vidIn.data[15:11], 3'h0, vidIn.data[10:5], 2'h0, vidIn.data[4:0], 3'h0};
      default: srcPix = '0;
    endcase
    // video range key on the source pixel, before zoom
    srcHit = inRange(srcPix.c0, cur.regs[vwo_pkg::A_KEYV], cur.regs[vwo_pkg::A_KEYM])
      && inRange(srcPix.c1, cur.regs[vwo_pkg::A_SMIN], cur.regs[vwo_pkg::A_SMAX])
      && inRange(srcPix.c2, cur.regs[vwo_pkg::A_TMIN], cur.regs[vwo_pkg::A_TMAX]);

    accept = vidIn.valid && cur.ready;
    if (accept) begin
      if (dfmt == vwo_pkg::DF_PACK) begin
        next_cur.chromaCnt = (cur.chromaCnt == vwo_pkg::PACK_LAST[1:0]) ? 2'h0 : cur.chromaCnt + 2'h1;
      end else begin
        next_cur.chromaCnt = {1'b0, ~cur.chromaCnt[0]};
      end
      next_cur.heldU = srcPix.c1;
      next_cur.heldV = srcPix.c2;
      if (!cur.validA) begin
        next_cur.pixA = srcPix;
        next_cur.hitA = srcHit;
        next_cur.validA = 1'b1;
      end else begin
        next_cur.pixB = srcPix;
        next_cur.hitB = srcHit;
        next_cur.validB = 1'b1;
      end
    end

    // horizontal zoom: phase step is the code, zero means unity
    hStep = (cur.regs[vwo_pkg::A_HZOOM] == 8'h00) ? vwo_pkg::ZOOM_UNITY : {1'b0, cur.regs[vwo_pkg::A_HZOOM]};
    hSum = {1'b0, cur.hPhase} + hStep;
    hW = 3'((9'(cur.hPhase) + vwo_pkg::W_ROUND) >> 6); // five levels 0..4
    mixPix.c0 = blend(cur.pixA.c0, cur.pixB.c0, hW);
    mixPix.c1 = blend(cur.pixA.c1, cur.pixB.c1, hW);
    mixPix.c2 = blend(cur.pixA.c2, cur.pixB.c2, hW);
    mixHit = (hW < 3'h2) ? cur.hitA : cur.hitB;

    // graphics color key by compare mode
    case (kmode)
      vwo_pkg::KM_MASK8: gMatch = ((dispIn.gfx[7:0] ^ cur.regs[vwo_pkg::A_KEYV])
        & ~cur.regs[vwo_pkg::A_KEYM]) == 8'h00;
      vwo_pkg::KM_FULL16: gMatch = dispIn.gfx == {cur.regs[vwo_pkg::A_KEYM], cur.regs[vwo_pkg::A_KEYV]};
      vwo_pkg::KM_TOPBIT: gMatch = dispIn.gfx[15] == cur.regs[vwo_pkg::A_KEYM][7];
      default: gMatch = 1'b0; // reserved mode never matches
    endcase

    // brightness on luma of YUV pixels, saturating
    bright = {1'b0, mixPix.c0} + {4'h0, cur.regs[vwo_pkg::A_BRIGHT][4:0]};

    // display output, paced by the refresh path
    next_cur.dout.valid = dispIn.valid;
    if (dispIn.valid) begin
      next_cur.dout.gfx = dispIn.gfx;
      next_cur.dout.video = mixPix;
      next_cur.dout.showVideo = 1'b0;
      if (dispIn.inWindow) begin // video only inside the window
        if (cur.validA && cur.validB) begin
          if ((dfmt == vwo_pkg::DF_YUV) || (dfmt == vwo_pkg::DF_PACK)) begin
            next_cur.dout.video.c0 = bright[8] ? 8'hFF : bright[7:0];
          end
          if (dfmt == 3'h3 || dfmt > vwo_pkg::DF_565) begin
            next_cur.dout.showVideo = 1'b0; // reserved format
          end else if (!occl) begin
            next_cur.dout.showVideo = 1'b1;
          end else if (!keySrc) begin
            next_cur.dout.showVideo = gMatch;
          end else begin
            next_cur.dout.showVideo = !mixHit;
          end
          next_cur.hPhase = hSum[7:0];
          if (hSum[8]) begin
            next_cur.pixA = cur.pixB;
            next_cur.hitA = cur.hitB;
            next_cur.validB = 1'b0;
          end
        end else begin
          next_cur.under = 1'b1; // starved: show graphics, flag it
        end
      end
    end
    next_cur.ready = !next_cur.validB;

    // underrun flag: write one clears, a new underrun wins
    if (regWrite && regAddr == vwo_pkg::A_STATUS && regWdata[vwo_pkg::ST_UNDER]
        && !(dispIn.valid && dispIn.inWindow && !(cur.validA && cur.validB))) begin
      next_cur.under = 1'b0;
    end

    // vertical zoom per display line
    vStep = (cur.regs[vwo_pkg::A_VZOOM] == 8'h00) ? vwo_pkg::ZOOM_UNITY : {1'b0, cur.regs[vwo_pkg::A_VZOOM]};
    vSum = {1'b0, cur.vPhase} + vStep;
    next_cur.lineAdv = 1'b0;
    if (dispIn.valid && dispIn.lineStart) begin
      next_cur.vPhase = vSum[7:0];
      next_cur.lineAdv = vSum[8];
      if (cur.regs[vwo_pkg::A_WINCTL][vwo_pkg::WC_LREP]) begin
        next_cur.vW = 3'h0; // replicate lines
      end else begin
        next_cur.vW = 3'((9'(vSum[7:0]) + vwo_pkg::W_ROUND) >> 6); // interpolate
      end
    end

    // capture field control
    next_cur.vrefPrev = capIn.vref;
    next_cur.enPrev = capOn;
    fieldOdd = capIn.href ^ cur.regs[vwo_pkg::A_B2HI][vwo_pkg::B2_POL];
    fieldMatch = !cur.regs[vwo_pkg::A_INCTL][vwo_pkg::IC_FS] || fieldOdd;
    if (capOn && !cur.enPrev) begin
      next_cur.armed = 1'b1; // wait for the next vertical pulse
    end
    if (!capOn) begin
      next_cur.armed = 1'b0;
      next_cur.take = 1'b0;
      next_cur.altSkip = 1'b0;
    end else if (cur.vrefPrev && !capIn.vref) begin
      next_cur.odd = fieldOdd;
      next_cur.armed = 1'b0;
      next_cur.take = 1'b0;
      if (fieldMatch) begin
        if (cur.regs[vwo_pkg::A_INCTL][vwo_pkg::IC_ALT] && cur.regs[vwo_pkg::A_INCTL][vwo_pkg::IC_FS]) begin
          next_cur.take = !cur.altSkip; // every other selected field
          next_cur.altSkip = !cur.altSkip;
        end else begin
          next_cur.take = 1'b1;
        end
      end
      next_cur.cout.addr = capBase;
    end

    // capture data formatting and store
    next_cur.cout.write = 1'b0;
    if (cur.take && capIn.vact) begin
      case (cfmt)
        vwo_pkg::CF_YUV, vwo_pkg::CF_RGB, vwo_pkg::CF_PACK: begin
          next_cur.cout.write = 1'b1;
          next_cur.cout.byteMode = 1'b0;
          next_cur.cout.data = capIn.data;
        end
        vwo_pkg::CF_COMP: begin // compress to one byte per pixel
          next_cur.cout.write = 1'b1;
          next_cur.cout.byteMode = 1'b1;
          next_cur.cout.data = {8'h00, capIn.data[15:11], capIn.data[7:5]};
        end
        vwo_pkg::CF_LUMA: begin // luma bytes only
          next_cur.cout.write = 1'b1;
          next_cur.cout.byteMode = 1'b1;
          next_cur.cout.data = {8'h00, capIn.data[15:8]};
        end
        default: next_cur.cout.write = 1'b0; // reserved: nothing stored
      endcase
      if (cur.cout.write) begin
        next_cur.cout.addr = cur.cout.addr + (cur.cout.byteMode ? 22'h000001 : 22'h000002);
      end
    end

    // display buffer start, low three bits zero
    next_cur.dispBase = {cur.regs[vwo_pkg::A_B1HI][3:0], cur.regs[vwo_pkg::A_B1MID],
      cur.regs[vwo_pkg::A_B1LO][7:1], 3'h0};
  end

  // capture buffer start, low three bits zero
  assign capBase = {cur.regs[vwo_pkg::A_B2HI][3:0], cur.regs[vwo_pkg::A_B2MID],
    cur.regs[vwo_pkg::A_B2LO][7:1], 3'h0};

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from state
  assign regRdata = cur.rdata;
  assign vidReady = cur.ready;
  assign dispOut = cur.dout;
  assign vLineAdvance = cur.lineAdv;
  assign vWeight = cur.vW;
  assign capOut = cur.cout;
  assign displayBase = cur.dispBase;
endmodule
